// [hw/sfpi_front.sv]
// Pin-level front end of a serial flash target port.
// Assumes pins are asynchronous to i_clk and sampled well above link rate.
//
// Contract
// [R1] Chip select high: deselected, every data line driver off.
// [R2] Chip select low: selected, shifts instructions in, data out.
// [R3] After power-up, no instruction until chip select falls once.
// [R4] Running internal cycle continues after chip select rises.
// [R5] Single mode: host drives line 0, sampled on rising clock.
// [R6] Single mode: read data driven on line 1 at falling clock.
// [R7] Dual/quad: lines bidirectional, in on rise, out on fall.
// [R8] Quad only with quad enable; lines 2 and 3 lose control roles.
// [R9] Write protect low with protect bits blocks status writes.
// [R10] Hold while selected: outputs off, clock and input ignored.
// [R11] Hold release resumes without losing shift state.
// [R12] Hold and shared reset only in single and dual transfers.
// [R13] Dedicated reset pin always resets regardless of configuration.
// [R14] Eight-pin, quad enable clear: line 3 is hold or reset.
// [R15] Eight-pin, quad enable set: line 3 neither hold nor reset.
// [R16] Host may force reset through the enabled reset input.
// [R17] Hold enters/leaves with clock low, else at next falling edge.
// [R18] Host keeps chip select low during hold; rising resets state.
// [R19] Hardware reset returns logic to power-on, aborts shifting; code keeps rx_sh, o_rx_byte and dout, and loads tx_sh from i_tx_byte.
// [R20] Undriven data lines keep their output drivers disabled.
`timescale 1ns/1ns
`default_nettype none
module sfpi_front
    import sfpi_pkg::*;
#(
    parameter bit HAS_RESET_PIN = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_cs_n,
    input  wire logic        i_sck,
    input  wire logic [3:0]  i_data_line,
    output logic      [3:0]  o_data_line,
    output logic      [3:0]  o_data_line_oe,
    input  wire logic        i_hw_reset_n,
    input  wire logic        i_quad_io_enable,
    input  wire logic        i_line3_is_reset,
    input  wire sfpi_prot_t  i_prot,
    input  wire sfpi_width_t i_width,
    input  wire logic        i_drive_out,
    input  wire logic [7:0]  i_tx_byte,
    input  wire logic        i_busy,
    output logic             o_tx_take,
    output logic      [7:0]  o_rx_byte,
    output logic             o_rx_valid,
    output logic             o_selected,
    output logic             o_hold,
    output logic             o_status_write_ok,
    output logic             o_busy,
    output logic             o_pin_reset
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] cs_s, sck_s, rst_s;
    logic [1:0] d_s [4];
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Reset low: a fall needs a real high sample first [R3]
            cs_s  <= 2'h0;
            sck_s <= 2'h0;
            rst_s <= 2'h3;
            for (int i = 0; i < 4; i++) d_s[i] <= 2'h3;
        end else begin
            cs_s  <= {cs_s[0], i_cs_n};
            sck_s <= {sck_s[0], i_sck};
            rst_s <= {rst_s[0], i_hw_reset_n};
            for (int i = 0; i < 4; i++) d_s[i] <= {d_s[i][0], i_data_line[i]};
        end
    end

    wire cs_n   = cs_s[1];
    wire sck    = sck_s[1];
    wire [3:0] din = {d_s[3][1], d_s[2][1], d_s[1][1], d_s[0][1]};
    logic sck_q, cs_q;
    wire sck_rise = sck & ~sck_q;
    wire sck_fall = ~sck & sck_q;
    wire cs_fall  = ~cs_n & cs_q;

    // ****************************************************************
    // Pin role selection
    // ****************************************************************
    wire quad_ok    = i_quad_io_enable;                  // [R8]
    wire quad_mode  = (i_width == SFPI_QUAD) & quad_ok;  // [R8]
    // Line 3 control roles only while quad enable clear
    wire l3_ctrl    = ~i_quad_io_enable;                 // [R12] [R15]
    wire hold_pin_n = (l3_ctrl & ~i_line3_is_reset) ? din[3] : 1'b1; // [R14]
    wire rst3_act   = l3_ctrl & i_line3_is_reset & ~din[3];          // [R14] [R16]
    wire rstp_act   = HAS_RESET_PIN & ~rst_s[1];         // [R13] [R16]
    wire pin_reset  = rst3_act | rstp_act;
    wire wp_n       = i_quad_io_enable ? 1'b1 : din[2];  // [R8]

    // Status write blocked by write protect when protect bits armed
    assign o_status_write_ok = ~(~wp_n &
        (i_prot.status_protect_bits != SFPI_SP_NONE));   // [R9]
    assign o_busy = i_busy;  // Internal cycle is not tied to select [R4]

    // ****************************************************************
    // Select, hold and shifting
    // ****************************************************************
    logic       armed;      // Set by first chip select fall [R3]
    logic       hold;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh, tx_sh;
    logic [3:0] dout;
    logic       out_en;

    wire selected  = ~cs_n & armed;                       // [R2] [R3]
    // Hold changes only while serial clock low or at its fall [R17]
    wire hold_req  = selected & ~hold_pin_n & ~quad_mode; // [R12]
    wire hold_step = ~sck | sck_fall;                     // [R17]
    wire next_hold = hold_step ? hold_req : hold;
    wire active    = selected & ~hold;                    // [R10]
    wire [2:0] step = (i_width == SFPI_DUAL) ? 3'h2 :
                      quad_mode ? 3'h4 : 3'h1;
    wire [3:0] step4 = {1'b0, step};
    wire [3:0] sum = {1'b0, bit_cnt} + step4;
    wire byte_done = sum[3];
    wire [7:0] rx_next = (i_width == SFPI_DUAL) ? {rx_sh[5:0], din[1:0]} :
                         quad_mode ? {rx_sh[3:0], din} :
                         {rx_sh[6:0], din[0]};            // [R5] [R7]
    wire [3:0] tx_bits = (i_width == SFPI_DUAL) ? {2'h0, tx_sh[7:6]} :
                         quad_mode ? tx_sh[7:4] : {2'h0, tx_sh[7], 1'b0};
    wire [3:0] oe_mask = (i_width == SFPI_DUAL) ? 4'h3 :
                         quad_mode ? 4'hf : 4'h2;          // [R6] [R7]

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b0;
            armed <= 1'b0;
        end else begin
            sck_q <= sck;
            cs_q  <= cs_n;
            if (pin_reset) armed <= 1'b0;                 // [R19]
            else if (cs_fall) armed <= 1'b1;              // [R3]
        end
    end

    // Shift state survives hold; only deselect or reset clears it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold       <= 1'b0;
            bit_cnt    <= SFPI_CNT_ZERO;
            rx_sh      <= SFPI_BYTE_ZERO;
            tx_sh      <= SFPI_BYTE_ZERO;
            o_rx_byte  <= SFPI_BYTE_ZERO;
            o_rx_valid <= 1'b0;
            dout       <= SFPI_NIB_ZERO;
            out_en     <= 1'b0;
        end else if (pin_reset || !selected) begin        // [R18] [R19]
            hold       <= 1'b0;
            bit_cnt    <= SFPI_CNT_ZERO;
            tx_sh      <= i_tx_byte;
            o_rx_valid <= 1'b0;
            out_en     <= 1'b0;                           // [R1]
        end else begin
            hold       <= next_hold;                      // [R11] [R17]
            o_rx_valid <= 1'b0;
            if (active && sck_rise && !i_drive_out) begin // [R5] [R7]
                rx_sh   <= rx_next;
                bit_cnt <= sum[2:0];
                if (byte_done) begin
                    o_rx_byte  <= rx_next;
                    o_rx_valid <= 1'b1;
                end
            end
            if (active && sck_fall && i_drive_out) begin  // [R6] [R7]
                dout    <= tx_bits;
                out_en  <= 1'b1;
                bit_cnt <= sum[2:0];
                tx_sh   <= byte_done ? i_tx_byte
                         : (tx_sh << step);
            end
            if (!i_drive_out) out_en <= 1'b0;
        end
    end

    assign o_tx_take  = active & sck_fall & i_drive_out & byte_done;
    assign o_selected = selected;
    assign o_hold     = hold;
    assign o_pin_reset = pin_reset;
    // Drivers off when deselected, held, or line not ours [R1] [R10] [R20]
    assign o_data_line_oe = (out_en & active) ? oe_mask : 4'h0;
    assign o_data_line    = dout & o_data_line_oe;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_desel_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        cs_n |-> (o_data_line_oe == 4'h0);
    endproperty
    a_desel_off: assert property (p_desel_off) // [R1]
        else $error("driver on while deselected");

    property p_armed_first;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!armed && !cs_fall) |=> !o_rx_valid;
    endproperty
    a_armed_first: assert property (p_armed_first) // [R3]
        else $error("byte accepted before select fall");

    property p_hold_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        hold |-> (o_data_line_oe == 4'h0) && !o_tx_take;
    endproperty
    a_hold_off: assert property (p_hold_off) // [R10]
        else $error("drive during hold");

    property p_hold_keep;
        @(posedge i_clk) disable iff (!i_reset_n)
        (hold && selected && !pin_reset) |=> $stable(bit_cnt);
    endproperty
    a_hold_keep: assert property (p_hold_keep) // [R11]
        else $error("shift state lost in hold");

    property p_no_quad_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_quad_io_enable |-> !rst3_act && !hold_req;
    endproperty
    a_no_quad_hold: assert property (p_no_quad_hold) // [R12] [R15]
        else $error("line 3 control in quad");

    property p_reset_pin;
        @(posedge i_clk) disable iff (!i_reset_n)
        (HAS_RESET_PIN && !rst_s[1]) |=> !armed && !o_selected;
    endproperty
    a_reset_pin: assert property (p_reset_pin) // [R13] [R19]
        else $error("reset pin ignored");

    property p_wp_block;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!i_quad_io_enable && !din[2] &&
         i_prot.status_protect_bits != SFPI_SP_NONE) |-> !o_status_write_ok;
    endproperty
    a_wp_block: assert property (p_wp_block) // [R9]
        else $error("status write not blocked");

    sequence s_fall_drive;
        active && sck_fall && i_drive_out;
    endsequence
    property p_out_fall;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(out_en) |-> $past(sck_fall);
    endproperty
    a_out_fall: assert property (p_out_fall) // [R6]
        else $error("output started off falling edge");

    property p_fall_oe;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_fall_drive ##1 (active && i_drive_out) |-> o_data_line_oe != 4'h0;
    endproperty
    a_fall_oe: assert property (p_fall_oe) // [R7] [R20]
        else $error("no drive after falling edge");

    property p_hold_enter;
        @(posedge i_clk) disable iff (!i_reset_n)
        (selected && !pin_reset && hold_req && !sck) |=> hold;
    endproperty
    a_hold_enter: assert property (p_hold_enter) // [R17]
        else $error("hold not entered with clock low");

    property p_hold_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        (selected && !pin_reset && sck) |=> $stable(hold);
    endproperty
    a_hold_wait: assert property (p_hold_wait) // [R17]
        else $error("hold changed with clock high");

    property p_rx_pulse;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_rx_valid |=> !o_rx_valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) // [R5]
        else $error("received byte strobe too long");

    property p_ctrl_lines_in;
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_quad_io_enable |-> (o_data_line_oe[3:2] == 2'h0);
    endproperty
    a_ctrl_lines_in: assert property (p_ctrl_lines_in) // [R8] [R14]
        else $error("control line driven without quad enable");

    property p_single_out;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_width == SFPI_SINGLE) |-> !o_data_line_oe[0];
    endproperty
    a_single_out: assert property (p_single_out) // [R5] [R6]
        else $error("input line driven in single mode");

    property p_in_phase_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_drive_out |=> (o_data_line_oe == 4'h0);
    endproperty
    a_in_phase_off: assert property (p_in_phase_off) // [R20]
        else $error("driver on during input phase");

    property p_desel_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        !selected |=> !hold && (bit_cnt == SFPI_CNT_ZERO);
    endproperty
    a_desel_clear: assert property (p_desel_clear) // [R18]
        else $error("state kept across deselect");

    property p_line3_reset;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!i_quad_io_enable && i_line3_is_reset && !din[3]) |=> !armed;
    endproperty
    a_line3_reset: assert property (p_line3_reset) // [R14] [R16]
        else $error("line 3 reset ignored");
endmodule // sfpi_front
`default_nettype wire

// [hw/sfpi_pkg.sv]
// Package for the serial flash pin front end: link modes and timing.
// Assumes a single system clock at 125 MHz.
package sfpi_pkg;
    // Transfer width chosen by the instruction decoder
    typedef enum logic [1:0] {
        SFPI_SINGLE,
        SFPI_DUAL,
        SFPI_QUAD
    } sfpi_width_t;

    // Protection bits held in the status register outside this block
    typedef struct packed {
        logic       protect_complement;
        logic       protect_top_bottom;
        logic [3:0] block_protect;
        logic [1:0] status_protect_bits;
    } sfpi_prot_t;

    localparam int         SFPI_SYNC_STAGES = 2;
    localparam int         SFPI_BYTE_BITS   = 8;
    localparam logic [2:0] SFPI_CNT_ZERO    = 3'h0;
    localparam logic [2:0] SFPI_CNT_LAST    = 3'h7;
    localparam logic [3:0] SFPI_NIB_ZERO    = 4'h0;
    localparam logic [7:0] SFPI_BYTE_ZERO   = 8'h00;
    localparam logic [1:0] SFPI_SP_NONE     = 2'h0;
endpackage

// [verification/sfpi_host.sv]
// Host controller model for the serial flash pin front end.
// Assumes the bench resolves each data line from both enables.
`timescale 1ns/1ns
`default_nettype none
module sfpi_host (
    output logic            o_cs_n,
    output logic            o_sck,
    output logic      [3:0] o_hd,
    output logic      [3:0] o_hoe,
    input  wire logic [3:0] i_line
);
    logic       wp_n     = 1'b1;
    logic       hold_n   = 1'b1;
    logic       quad_drv = 1'b0;
    logic [1:0] lo       = 2'h0;
    logic [1:0] qd       = 2'h0;
    // Lines 2 and 3 carry protect and hold unless quad data is sent
    assign o_hd = {(quad_drv ? qd : {hold_n, wp_n}), lo};
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_hoe  = 4'hC;
    end
    // ****************************************
    // Framing
    // ****************************************
    task automatic frame_begin();
        #100 o_cs_n = 1'b0;
        #100;
    endtask
    // Select released only between frames, never during hold
    task automatic frame_end();
        #100 o_cs_n = 1'b1;
        #100;
    endtask
    // n clocks of w bits each, MSB first; reads line 1 on each rise
    task automatic shift(input int n, input int w, input logic [3:0] m,
                         input logic [7:0] tx, output logic [7:0] rx);
        int b;
        logic [3:0] v;
        o_hoe = m;
        rx = 8'h00;
        b = 7;
        for (int k = 0; k < n; k++) begin
            v = 4'h0;
            for (int j = 0; j < w; j++) begin
                v[(w == 1) ? 0 : w - 1 - j] = tx[b & 7];
                b--;
            end
            lo = v[1:0];
            qd = v[3:2];
            quad_drv = (w == 4);
            #62 o_sck = 1'b1;
            rx = {rx[6:0], i_line[1]};
            #63 o_sck = 1'b0;
        end
        quad_drv = 1'b0;
        o_hoe = 4'hC;
    endtask
endmodule // sfpi_host
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the serial flash pin front end.
// Assumes the host model in sfpi_host.sv and a 125 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
module tb
    import sfpi_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_reset_n, hw_n, qe, l3_rst, drv, busy;
    logic        cs_n, sck, tk, rxv, sel, hold, wok, busy_o, prst;
    logic [3:0]  hd, hoe, od, oe, line;
    logic [7:0]  txb, rxb, last_rx, r;
    sfpi_prot_t  prot;
    sfpi_width_t wid;
    int          err_count = 0;
    int          checks_done = 0;
    int          rx_cnt = 0;
    int          tk_cnt = 0;
    logic [3:0]  last_od = 4'h0;
    // Undriven line shows the inverse of the device's last output bit
    assign line = (oe & od) | (~oe & hoe & hd) | (~oe & ~hoe & ~last_od);
    always @(posedge i_clk) last_od <= (oe & od) | (~oe & last_od);
    always #4 i_clk = ~i_clk;
    sfpi_host host (.o_cs_n(cs_n), .o_sck(sck), .o_hd(hd), .o_hoe(hoe),
                    .i_line(line));
    sfpi_front DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(cs_n),
        .i_sck(sck), .i_data_line(line), .o_data_line(od),
        .o_data_line_oe(oe), .i_hw_reset_n(hw_n), .i_quad_io_enable(qe),
        .i_line3_is_reset(l3_rst), .i_prot(prot), .i_width(wid),
        .i_drive_out(drv), .i_tx_byte(txb), .i_busy(busy), .o_tx_take(tk),
        .o_rx_byte(rxb), .o_rx_valid(rxv), .o_selected(sel), .o_hold(hold),
        .o_status_write_ok(wok), .o_busy(busy_o), .o_pin_reset(prst));
    always @(posedge i_clk) begin
        if (rxv === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            last_rx <= rxb;
        end
        if (tk === 1'b1) tk_cnt <= tk_cnt + 1;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic conclude();
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wait_rx(input int n, input logic [7:0] e);
        wt(1);
        for (int i = 0; i < 40 && rx_cnt != n; i++) wt(1);
        if (rx_cnt != n) begin
            err_count++;
            $display("BAD rx_count expected %0d seen %0d", n, rx_cnt);
            conclude();
        end
        chk("rx_byte", e, last_rx);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_select();
        host.shift(8, 1, 4'hD, 8'h5A, r);
        wt(20);
        chk("rx_count_no_fall", 8'h00, rx_cnt[7:0]);
        host.frame_end();
        chk("oe_deselected", 8'h00, 8'(oe));
        chk("sel_high_cs", 8'h00, 8'(sel));
        host.frame_begin();
        chk("sel_low_cs", 8'h01, 8'(sel));
        host.shift(8, 1, 4'hD, 8'hA5, r);
        wait_rx(1, 8'hA5);
        chk("oe_input_phase", 8'h00, 8'(oe));
    endtask
    task automatic t_tx();
        host.frame_end();
        wt(1);
        drv = 1'b1;
        txb = 8'h3C;
        host.frame_begin();
        // Lead clock: its fall puts out the first bit
        host.shift(9, 1, 4'hC, 8'h00, r);
        wt(8);
        chk("read_byte", 8'h3C, r);
        chk("oe_single_out", 8'h02, 8'(oe));
        chk("tx_take_count", 8'h01, tk_cnt[7:0]);
        drv = 1'b0;
        host.frame_end();
        host.frame_begin();
    endtask
    task automatic t_widths();
        sfpi_width_t wl [3] = '{SFPI_DUAL, SFPI_QUAD, SFPI_QUAD};
        logic qel [3] = '{1'b0, 1'b1, 1'b0};
        int nl [3] = '{4, 2, 8};
        wt(1);
        for (int k = 0; k < 3; k++) begin
            wid = wl[k];
            qe = qel[k];
            wt(2);
            host.shift(nl[k], 8 / nl[k], 4'hF, 8'h1B + 8'(k * 68), r);
            wait_rx(2 + k, 8'h1B + 8'(k * 68));
        end
        // Quad read: one fall puts the high nibble on all four lines
        drv = 1'b1;
        qe = 1'b1;
        txb = 8'hC5;
        host.frame_end();
        host.frame_begin();
        host.shift(1, 4, 4'h0, 8'h00, r);
        wt(4);
        chk("quad_oe", 8'h0F, 8'(oe));
        chk("quad_out", 8'h0C, 8'(od));
        drv = 1'b0;
        host.frame_end();
        host.frame_begin();
        wt(1);
        wid = SFPI_SINGLE;
        qe = 1'b0;
    endtask
    task automatic t_hold();
        host.shift(4, 1, 4'hD, 8'h90, r);
        host.hold_n = 1'b0;
        wt(8);
        chk("hold_on", 8'h01, 8'(hold));
        host.shift(2, 1, 4'hD, 8'hFF, r);
        host.hold_n = 1'b1;
        wt(8);
        chk("hold_off", 8'h00, 8'(hold));
        host.shift(4, 1, 4'hD, 8'h60, r);
        wait_rx(5, 8'h96);
        qe = 1'b1;
        host.hold_n = 1'b0;
        wt(8);
        chk("hold_quad", 8'h00, 8'(hold));
        host.hold_n = 1'b1;
        qe = 1'b0;
    endtask
    task automatic t_prot();
        prot.status_protect_bits = 2'h1;
        host.wp_n = 1'b0;
        wt(8);
        chk("wok_wp_low", 8'h00, 8'(wok));
        qe = 1'b1;
        wt(8);
        chk("wok_quad", 8'h01, 8'(wok));
        qe = 1'b0;
        host.wp_n = 1'b1;
        wt(8);
        chk("wok_wp_high", 8'h01, 8'(wok));
        prot = '0;
    endtask
    task automatic t_resets();
        hw_n = 1'b0;
        qe = 1'b1;
        wt(8);
        chk("pin_rst_dedicated", 8'h01, 8'(prst));
        hw_n = 1'b1;
        wt(8);
        chk("sel_after_reset", 8'h00, 8'(sel));
        qe = 1'b0;
        l3_rst = 1'b1;
        host.hold_n = 1'b0;
        wt(8);
        chk("pin_rst_line3", 8'h01, 8'(prst));
        qe = 1'b1;
        wt(8);
        chk("pin_rst_line3_quad", 8'h00, 8'(prst));
        host.hold_n = 1'b1;
        qe = 1'b0;
        l3_rst = 1'b0;
    endtask
    task automatic t_busy();
        busy = 1'b1;
        host.frame_end();
        chk("busy_deselected", 8'h01, 8'(busy_o));
        wt(1);
        busy = 1'b0;
        wt(4);
        chk("busy_clear", 8'h00, 8'(busy_o));
    endtask
    initial begin
        {i_reset_n, drv, busy, qe, l3_rst} = '0;
        hw_n = 1'b1;
        txb = 8'h00;
        prot = '0;
        wid = SFPI_SINGLE;
        // Select held low across reset: no falling edge is seen
        #1 host.o_cs_n = 1'b0;
        wt(16);
        i_reset_n = 1'b1;
        wt(4);
        t_select();
        t_tx();
        t_widths();
        t_hold();
        t_prot();
        t_resets();
        t_busy();
        conclude();
    end
endmodule // tb
`default_nettype wire
